// ==== xtio_pkg.sv ====
package xtio_pkg;
   // port addresses (10-bit i/o space)
   localparam logic [9:0] XTIO_DMA_LO      = 10'h000;
   localparam logic [9:0] XTIO_DMA_HI      = 10'h00f;
   localparam logic [9:0] XTIO_PIC_LO      = 10'h020;
   localparam logic [9:0] XTIO_PIC_HI      = 10'h021;
   localparam logic [9:0] XTIO_INDEX_ADDR  = 10'h026;
   localparam logic [9:0] XTIO_DATA_ADDR   = 10'h027;
   localparam logic [9:0] XTIO_TMR_LO      = 10'h040;
   localparam logic [9:0] XTIO_TMR_HI      = 10'h043;
   localparam logic [9:0] XTIO_SCAN_ADDR   = 10'h060;
   localparam logic [9:0] XTIO_CTRL_ADDR   = 10'h061;
   localparam logic [9:0] XTIO_STAT_ADDR   = 10'h062;
   localparam logic [9:0] XTIO_MAPPG_ADDR  = 10'h06c;
   localparam logic [9:0] XTIO_MAPD_LO     = 10'h06e;
   localparam logic [9:0] XTIO_MAPD_HI     = 10'h06f;
   localparam logic [9:0] XTIO_DPG_LO      = 10'h081;
   localparam logic [9:0] XTIO_DPG_HI      = 10'h083;
   // internal index of the main nmi status register
   localparam logic [7:0] XTIO_NMI_STAT_IDX = 8'h19;
   // nmi status bit that reports the keyboard-clock request
   localparam int         XTIO_NMI_KBD_BIT  = 1;
   // control port field positions
   localparam int XTIO_CTL_KBD_CLEAR   = 7;
   localparam int XTIO_CTL_KCLK_EN     = 6;
   localparam int XTIO_CTL_IOPAR_DIS   = 5;
   localparam int XTIO_CTL_RAMPAR_DIS  = 4;
   localparam int XTIO_CTL_SW_GROUP    = 3;
   localparam int XTIO_CTL_SPARE       = 2;
   localparam int XTIO_CTL_SPK_EN      = 1;
   localparam int XTIO_CTL_T2_GATE     = 0;
   // reset values
   localparam logic [7:0] XTIO_INDEX_RST = 8'h00;
   localparam logic [7:0] XTIO_SCAN_RST  = 8'h00;
   localparam logic [7:0] XTIO_CTRL_RST  = 8'h00;
   // internal register file depth
   localparam int XTIO_IREG_DEPTH = 256;
   // peripheral select codes
   typedef enum logic [3:0] {
      XTIO_SEL_NONE = 4'h0,
      XTIO_SEL_DMA  = 4'h1,
      XTIO_SEL_PIC  = 4'h2,
      XTIO_SEL_TMR  = 4'h3,
      XTIO_SEL_MAPP = 4'h4,
      XTIO_SEL_MAPD = 4'h5,
      XTIO_SEL_DPG  = 4'h6,
      XTIO_SEL_EXT  = 4'h7
   } xtio_sel_type;
endpackage

// ==== xtio_decode.sv ====
`timescale 1ns/100ps
// fixed-range decode of the standard peripherals
module xtio_decode
(
   input  wire logic [9:0]           io_addr,
   input  wire logic                 ext_kbd,
   output xtio_pkg::xtio_sel_type    sel
);
   // range test used for every multi-port window
   function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo,
                                     input logic [9:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   wire logic hit_dma  = in_range(io_addr, xtio_pkg::XTIO_DMA_LO, xtio_pkg::XTIO_DMA_HI);
   wire logic hit_pic  = in_range(io_addr, xtio_pkg::XTIO_PIC_LO, xtio_pkg::XTIO_PIC_HI);
   wire logic hit_tmr  = in_range(io_addr, xtio_pkg::XTIO_TMR_LO, xtio_pkg::XTIO_TMR_HI);
   wire logic hit_mapp = (io_addr == xtio_pkg::XTIO_MAPPG_ADDR);
   wire logic hit_mapd = in_range(io_addr, xtio_pkg::XTIO_MAPD_LO, xtio_pkg::XTIO_MAPD_HI);
   wire logic hit_dpg  = in_range(io_addr, xtio_pkg::XTIO_DPG_LO, xtio_pkg::XTIO_DPG_HI);
   // scan port goes outside when the external keyboard is chosen
   wire logic hit_ext  = ext_kbd && (io_addr == xtio_pkg::XTIO_SCAN_ADDR);

   // priority order is irrelevant, windows do not overlap
   assign sel = hit_dma  ? xtio_pkg::XTIO_SEL_DMA  :
                hit_pic  ? xtio_pkg::XTIO_SEL_PIC  :
                hit_tmr  ? xtio_pkg::XTIO_SEL_TMR  :
                hit_mapp ? xtio_pkg::XTIO_SEL_MAPP :
                hit_mapd ? xtio_pkg::XTIO_SEL_MAPD :
                hit_dpg  ? xtio_pkg::XTIO_SEL_DPG  :
                hit_ext  ? xtio_pkg::XTIO_SEL_EXT  :
                           xtio_pkg::XTIO_SEL_NONE;
endmodule // xtio_decode

// ==== xtio_top.sv ====
`timescale 1ns/100ps
// Functional notes
// - internal registers reached via index 026h, data 027h
// - index port read/write, clears on reset
// - data window reads/writes selected register
// - decode dma, interrupt controller, timer ranges
// - decode map page, map data, dma page ports
// - decode control 061h, status 062h, scan 060h
// - control d7 clears scan data and irq1
// - control d6 enables keyboard clock, resets low
// - low-then-high clock bit write raises nmi in internal scan mode
// - d5 io parity disable, d4 ram parity disable
// - d3 picks switch group on status port
// - d1 gates speaker output
// - d0 gates timer channel 2
// - nmi source reported at internal index 19h
// - status gives timer out, inverted speaker, zero parity
module xtio_top
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [9:0]  io_addr,       // processor i/o address
   input  wire logic        io_rd,         // one-cycle read strobe
   input  wire logic        io_wr,         // one-cycle write strobe
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,      // valid cycle after io_rd
   output logic             io_rvalid,     // read answered by this block
   output logic      [3:0]  periph_sel,    // registered peripheral select
   output logic             periph_rd,
   output logic             periph_wr,
   output logic      [7:0]  periph_wdata,
   input  wire logic [7:0]  periph_rdata,  // sampled in the io_rd cycle, one before periph_rd
   input  wire logic        external_keyboard_select, // from keyboard mode reg
   input  wire logic        internal_scan_mode,
   input  wire logic        kbd_irq_in,    // irq1 request from scanner
   input  wire logic        timer2_out,    // timer channel 2 output
   input  wire logic [7:0]  switch_bits,   // switches 1..8
   output logic             kbd_clear,
   output logic             kbd_clock_enable,
   output logic             io_channel_parity_disable,
   output logic             ram_parity_disable,
   output logic             switch_group_select,
   output logic             speaker_output_enable,
   output logic             timer2_gate,
   output logic             speaker_pin,   // gated speaker level
   output logic             kbd_irq,       // irq1 toward interrupt controller
   output logic             nmi_req        // level until source cleared
);
   // selected peripheral from the decoder
   xtio_pkg::xtio_sel_type sel;

   xtio_decode u_dec
   (
      .io_addr (io_addr),
      .ext_kbd (external_keyboard_select),
      .sel     (sel)
   );

   // storage
   logic [7:0] index_q;                    // index select
   logic [7:0] scan_q;                     // scan code port
   logic [7:0] ctrl_q;                     // keyboard/speaker control
   logic       clk_low_seen_q;             // last ctrl write had clock bit low
   logic       nmi_kbd_q;                  // sticky keyboard nmi source
   logic       irq_q;                      // pending irq1
   logic [7:0] ireg_q [xtio_pkg::XTIO_IREG_DEPTH]; // chip-specific registers

   // local hits
   wire logic hit_idx  = (io_addr == xtio_pkg::XTIO_INDEX_ADDR);
   wire logic hit_dat  = (io_addr == xtio_pkg::XTIO_DATA_ADDR);
   wire logic hit_scan = (io_addr == xtio_pkg::XTIO_SCAN_ADDR) && !external_keyboard_select;
   wire logic hit_ctrl = (io_addr == xtio_pkg::XTIO_CTRL_ADDR);
   wire logic hit_stat = (io_addr == xtio_pkg::XTIO_STAT_ADDR);
   wire logic hit_ext  = (sel != xtio_pkg::XTIO_SEL_NONE);

   // write strobes
   wire logic wr_idx  = io_wr && hit_idx;
   wire logic wr_dat  = io_wr && hit_dat;
   wire logic wr_scan = io_wr && hit_scan;
   wire logic wr_ctrl = io_wr && hit_ctrl;
   wire logic wr_nmi  = wr_dat && (index_q == xtio_pkg::XTIO_NMI_STAT_IDX);

   // keyboard nmi: clock bit low in previous write, high now
   wire logic kclk_new = io_wdata[xtio_pkg::XTIO_CTL_KCLK_EN];
   wire logic kbd_nmi_evt = wr_ctrl && internal_scan_mode && clk_low_seen_q && kclk_new;
   // clear bit in control port flushes data and irq1
   wire logic clr_now = ctrl_q[xtio_pkg::XTIO_CTL_KBD_CLEAR];

   // status port composition
   wire logic [3:0] sw_grp = ctrl_q[xtio_pkg::XTIO_CTL_SW_GROUP] ? switch_bits[7:4]
                                                                 : switch_bits[3:0];
   wire logic [7:0] stat_val = {2'b00, timer2_out, ~speaker_pin, sw_grp};

   // nmi status image: hardware source overlays the stored byte
   // the clearing write lands in the array too, so its stored copy of the bit is masked
   wire logic [7:0] nmi_kbd_mask = 8'h01 << xtio_pkg::XTIO_NMI_KBD_BIT;
   wire logic [7:0] nmi_stat_val = (ireg_q[xtio_pkg::XTIO_NMI_STAT_IDX] & ~nmi_kbd_mask)
                                   | (nmi_kbd_mask & {8{nmi_kbd_q}});
   wire logic [7:0] win_val = (index_q == xtio_pkg::XTIO_NMI_STAT_IDX) ? nmi_stat_val
                                                                        : ireg_q[index_q];

   // read mux
   wire logic [7:0] rd_mux = hit_idx  ? index_q      :
                             hit_dat  ? win_val      :
                             hit_scan ? scan_q       :
                             hit_ctrl ? ctrl_q       :
                             hit_stat ? stat_val     :
                             hit_ext  ? periph_rdata :
                                        8'h00;
   wire logic rd_ours = hit_idx || hit_dat || hit_scan || hit_ctrl || hit_stat || hit_ext;

   // index select register
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         index_q <= xtio_pkg::XTIO_INDEX_RST;
      else if (wr_idx)
         index_q <= io_wdata;
   end

   // internal register file, written through the window
   always_ff @(posedge clk_sys)
   begin
      if (wr_dat)
         ireg_q[index_q] <= io_wdata;
   end

   // scan code port; cleared while control d7 is set
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         scan_q <= xtio_pkg::XTIO_SCAN_RST;
      else if (clr_now)
         scan_q <= 8'h00;
      else if (wr_scan)
         scan_q <= io_wdata;
   end

   // control port and clock-low history
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl_q         <= xtio_pkg::XTIO_CTRL_RST;
         clk_low_seen_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         ctrl_q         <= io_wdata;
         clk_low_seen_q <= !kclk_new;
      end
   end

   // keyboard nmi source; set wins over software clear
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         nmi_kbd_q <= 1'b0;
      else if (kbd_nmi_evt)
         nmi_kbd_q <= 1'b1;
      else if (wr_nmi && io_wdata[xtio_pkg::XTIO_NMI_KBD_BIT])
         nmi_kbd_q <= 1'b0;                             // write one to clear
   end

   // pending irq1; request wins unless clear bit held
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         irq_q <= 1'b0;
      else if (clr_now)
         irq_q <= 1'b0;
      else if (kbd_irq_in)
         irq_q <= 1'b1;
      else if (io_rd && hit_scan)
         irq_q <= 1'b0;                                 // reading the code acknowledges
   end

   // read answer and peripheral strobes, one cycle later
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         io_rdata     <= 8'h00;
         io_rvalid    <= 1'b0;
         periph_sel   <= 4'h0;
         periph_rd    <= 1'b0;
         periph_wr    <= 1'b0;
         periph_wdata <= 8'h00;
      end
      else
      begin
         io_rdata     <= io_rd ? rd_mux : 8'h00;
         io_rvalid    <= io_rd && rd_ours;
         periph_sel   <= sel;
         periph_rd    <= io_rd && hit_ext;
         periph_wr    <= io_wr && hit_ext;
         periph_wdata <= io_wdata;
      end
   end

   // control outputs straight from flops
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         kbd_clear                 <= 1'b0;
         kbd_clock_enable          <= 1'b0;
         io_channel_parity_disable <= 1'b0;
         ram_parity_disable        <= 1'b0;
         switch_group_select       <= 1'b0;
         speaker_output_enable     <= 1'b0;
         timer2_gate               <= 1'b0;
         speaker_pin               <= 1'b0;
         kbd_irq                   <= 1'b0;
         nmi_req                   <= 1'b0;
      end
      else
      begin
         kbd_clear                 <= ctrl_q[xtio_pkg::XTIO_CTL_KBD_CLEAR];
         kbd_clock_enable          <= ctrl_q[xtio_pkg::XTIO_CTL_KCLK_EN];
         io_channel_parity_disable <= ctrl_q[xtio_pkg::XTIO_CTL_IOPAR_DIS];
         ram_parity_disable        <= ctrl_q[xtio_pkg::XTIO_CTL_RAMPAR_DIS];
         switch_group_select       <= ctrl_q[xtio_pkg::XTIO_CTL_SW_GROUP];
         speaker_output_enable     <= ctrl_q[xtio_pkg::XTIO_CTL_SPK_EN];
         timer2_gate               <= ctrl_q[xtio_pkg::XTIO_CTL_T2_GATE];
         // speaker sounds only with both timer 2 output and enable
         speaker_pin               <= timer2_out && ctrl_q[xtio_pkg::XTIO_CTL_SPK_EN];
         kbd_irq                   <= irq_q;
         nmi_req                   <= nmi_kbd_q;
      end
   end
endmodule // xtio_top

// ==== xtio_top_chk.sv ====
`timescale 1ns/100ps
// port-level checker for the i/o decode and index block
module xtio_top_chk
(
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic [9:0] io_addr,
   input wire logic       io_rd,
   input wire logic       io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       io_rvalid,
   input wire logic [3:0] periph_sel,
   input wire logic       periph_rd,
   input wire logic       external_keyboard_select,
   input wire logic       timer2_out,
   input wire logic [7:0] switch_bits,
   input wire logic       kbd_clear,
   input wire logic       kbd_clock_enable,
   input wire logic       io_channel_parity_disable,
   input wire logic       ram_parity_disable,
   input wire logic       switch_group_select,
   input wire logic       speaker_output_enable,
   input wire logic       timer2_gate,
   input wire logic       kbd_irq,
   input wire logic       nmi_req
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   dma_dec_a:
      assert property (io_rd && io_addr <= 10'h00f |=> periph_rd && periph_sel == 4'h1)
         else $error("dma range not selected");
   unmap_rd_a:
      assert property (io_rd && io_addr == 10'h084 |=> !io_rvalid && io_rdata == 8'h00)
         else $error("unmapped read answered");
   map_dec_a:
      assert property (io_rd && io_addr == 10'h06e |=> periph_rd && periph_sel == 4'h5)
         else $error("map data port not selected");
   ext_scan_a:
      assert property (io_rd && io_addr == 10'h060 && external_keyboard_select
                       |=> periph_sel == 4'h7)
         else $error("scan port not handed off");
   ctrl_out_a:
      assert property (io_wr && io_addr == 10'h061 |=> ##1
         {kbd_clear, kbd_clock_enable, io_channel_parity_disable, ram_parity_disable,
          switch_group_select, speaker_output_enable, timer2_gate}
         == {$past(io_wdata[7:3], 2), $past(io_wdata[1:0], 2)})
         else $error("control outputs differ from written byte");
   idx_rd_a:
      assert property (io_rd && io_addr == 10'h026 |=> io_rvalid)
         else $error("index read not answered");
   stat_rd_a:
      assert property (io_rd && io_addr == 10'h062 |=> io_rdata[7:6] == 2'b00
         && io_rdata[5] == $past(timer2_out) && io_rdata[3:0] ==
         (switch_group_select ? $past(switch_bits[7:4]) : $past(switch_bits[3:0])))
         else $error("status byte wrong");
   kbd_clr_a:
      assert property (kbd_clear && $past(kbd_clear) |-> !kbd_irq)
         else $error("irq1 kept while keyboard cleared");
   nmi_src_a:
      assert property ($rose(nmi_req) |-> $past(io_wr && io_addr == 10'h061 && io_wdata[6], 2))
         else $error("nmi without clock-enable write");
endmodule // xtio_top_chk

bind xtio_top xtio_top_chk u_chk (.clk_sys, .srst, .io_addr, .io_rd, .io_wr, .io_wdata,
   .io_rdata, .io_rvalid, .periph_sel, .periph_rd, .external_keyboard_select, .timer2_out,
   .switch_bits, .kbd_clear, .kbd_clock_enable, .io_channel_parity_disable,
   .ram_parity_disable, .switch_group_select, .speaker_output_enable, .timer2_gate,
   .kbd_irq, .nmi_req);

// ==== xtio_cpu_model.sv ====
`timescale 1ns/100ps
// processor core: one-cycle i/o strobes, bus moves only after edges
module xtio_cpu_model
(
   input  wire logic       clk_sys,
   output logic      [9:0] io_addr,
   output logic            io_rd,
   output logic            io_wr,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata,
   input  wire logic       io_rvalid
);
   initial
   begin
      io_addr = 10'h000;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 8'h00;
   end
   // write cycle; data inverted on release so stale bytes never match
   task automatic wr(input logic [9:0] a, input logic [7:0] b);
      @(posedge clk_sys);
      io_addr <= a;
      io_wdata <= b;
      io_wr <= 1'b1;
      @(posedge clk_sys);
      io_wr <= 1'b0;
      io_wdata <= ~b;
   endtask
   // read cycle; answer lands on the edge that takes the strobe
   task automatic rd(input logic [9:0] a, output logic [7:0] b, output logic v);
      @(posedge clk_sys);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk_sys);
      io_rd <= 1'b0;
      #1;
      b = io_rdata;
      v = io_rvalid;
   endtask
endmodule // xtio_cpu_model

// ==== tb_xt_io_decode_and_index_port.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_xt_io_decode_and_index_port;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [9:0]  io_addr;
   logic        io_rd, io_wr, io_rvalid, periph_rd, periph_wr, v;
   logic [7:0]  io_wdata, io_rdata, periph_wdata, d, idx;
   logic [3:0]  periph_sel;
   logic [7:0]  periph_rdata = 8'h00, switch_bits = 8'h00;
   logic        ext_sel = 1'b0, scan_mode = 1'b0, irq_in = 1'b0, t2 = 1'b0;
   logic        speaker_pin, kbd_irq, nmi_req;
   logic [6:0]  ctl;
   logic [31:0] seed = 32'h0000003f, r;
   int          err_total = 0, checks = 0;
   // decode table: address and expected select code
   logic [9:0]  dec_a [12] = '{10'h000, 10'h00f, 10'h020, 10'h021, 10'h040, 10'h043,
                              10'h06c, 10'h06e, 10'h06f, 10'h081, 10'h083, 10'h084};
   logic [3:0]  dec_s [12] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h5,
                              4'h6, 4'h6, 4'h0};

   always #2.5 clk_sys = ~clk_sys;

   xtio_cpu_model cpu (.clk_sys, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rvalid);
   xtio_top uut
   (
      .clk_sys, .srst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rvalid,
      .periph_sel, .periph_rd, .periph_wr, .periph_wdata, .periph_rdata,
      .external_keyboard_select(ext_sel), .internal_scan_mode(scan_mode),
      .kbd_irq_in(irq_in), .timer2_out(t2), .switch_bits, .kbd_clear(ctl[6]),
      .kbd_clock_enable(ctl[5]), .io_channel_parity_disable(ctl[4]),
      .ram_parity_disable(ctl[3]), .switch_group_select(ctl[2]),
      .speaker_output_enable(ctl[1]), .timer2_gate(ctl[0]), .speaker_pin, .kbd_irq, .nmi_req
   );

   // xorshift source, fixed start so runs repeat
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected status byte: parity flags low, timer, inverted speaker, switches
   function automatic logic [7:0] stat_exp(logic [7:0] sw, logic g, logic t, logic spk);
      return {2'b00, t, ~spk, g ? sw[7:4] : sw[3:0]};
   endfunction
   task automatic report_and_stop();
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog well beyond the roughly 500 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      report_and_stop();
   end

   initial
   begin
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      cpu.rd(10'h026, d, v);
      `CHK({v, d}, 9'h100)
      cpu.rd(10'h061, d, v);
      `CHK(d, 8'h00)
      // index, window and control with random bytes, scan mode off
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         idx = (r[7:0] == 8'h19) ? 8'h18 : r[7:0];
         cpu.wr(10'h026, idx);
         cpu.wr(10'h027, r[15:8]);
         cpu.rd(10'h026, d, v);
         `CHK(d, idx)
         cpu.rd(10'h027, d, v);
         `CHK(d, r[15:8])
         cpu.wr(10'h061, r[23:16]);
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK({nmi_req, ctl}, {1'b0, r[23:19], r[17:16]})
         cpu.rd(10'h061, d, v);
         `CHK(d, r[23:16])
      end
      // fixed peripheral ranges pass the far side byte through
      for (int i = 0; i < 12; i++)
      begin
         r = rnd();
         @(posedge clk_sys);
         periph_rdata <= r[7:0];
         cpu.rd(dec_a[i], d, v);
         `CHK({periph_sel, v, d}, (|dec_s[i]) ? {dec_s[i], 1'b1, r[7:0]} : 13'h0)
         cpu.wr(dec_a[i], r[15:8]);
         #1;
         `CHK({periph_wr, periph_wdata}, {|dec_s[i], r[15:8]})
      end
      // scan port stored, handed off, then cleared
      cpu.wr(10'h061, 8'h00);
      cpu.wr(10'h060, 8'h5a);
      cpu.rd(10'h060, d, v);
      `CHK(d, 8'h5a)
      @(posedge clk_sys);
      ext_sel <= 1'b1;
      irq_in <= 1'b1;
      periph_rdata <= 8'hc3;
      cpu.rd(10'h060, d, v);
      `CHK({periph_sel, d}, 12'h7c3)
      `CHK(kbd_irq, 1'b1)
      @(posedge clk_sys);
      ext_sel <= 1'b0;
      cpu.wr(10'h061, 8'h80);
      repeat (2) @(posedge clk_sys);
      cpu.rd(10'h060, d, v);
      `CHK({kbd_irq, d}, 9'h000)
      // status port over both switch groups and speaker gate
      for (int i = 0; i < 4; i++)
      begin
         r = rnd();
         @(posedge clk_sys);
         switch_bits <= r[7:0];
         t2 <= r[8];
         cpu.wr(10'h061, {4'h0, i[0], 1'b0, i[1], 1'b0});
         repeat (3) @(posedge clk_sys);
         #1;
         `CHK(speaker_pin, r[8] & i[1])
         cpu.rd(10'h062, d, v);
         `CHK(d, stat_exp(r[7:0], i[0], r[8], r[8] & i[1]))
      end
      // handler reads status first, then clears the keyboard source
      @(posedge clk_sys);
      scan_mode <= 1'b1;
      cpu.wr(10'h061, 8'h00);
      cpu.wr(10'h061, 8'h40);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(nmi_req, 1'b1)
      cpu.wr(10'h026, 8'h19);
      cpu.rd(10'h027, d, v);
      `CHK(d[1], 1'b1)
      cpu.wr(10'h027, 8'h02);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(nmi_req, 1'b0)
      cpu.rd(10'h027, d, v);
      `CHK(d[1], 1'b0)
      report_and_stop();
   end
endmodule // tb_xt_io_decode_and_index_port
